// >>> common/ddsc_cfg.svh
// Notes on behaviour
// - Dimming source: pin at 0, counter at 1
// - Internal dimming ignores the dimming pins
// - Per channel 10-bit counter, split duty
// - Duty passes on only at low-part write
// - Pending duty loads at count 1022
// - Dimming clock divided by 2^code, 3-bit code (1 to 128)
// - Phase bit 0: 180 degrees; 1: in phase
// - Dimming low: gate, compensation, FET off
// - Rise: drive on, connect once sense exceeds
// - Internal select resets to 0, channel off
// - FET drive follows dimming, gated by enable
// - 8-bit ramp 0..255 on divided switch clock
// - Ramp runs while dimming high, else holds
// - Source change may disturb one period
// - Dual phase: amplifier two off, tied
// - Dual phase: one divider, 180 degrees, ramp
// - Dual phase: channel one duty drives both
// - Dual phase: channel two faults ignored
// - 3-bit trim, 2.5 mV steps to 17.5
// - Gate-off bit stops only that channel
`ifndef DDSC_CFG_SVH
`define DDSC_CFG_SVH
`define DDSC_CNT_W 10
`define DDSC_DUTY_LOAD 10'h3FE
`define DDSC_PHASE_OFS 10'h200
`define DDSC_RAMP_MAX 8'hFF
`define DDSC_TRIM_STEP_UV 15'h09C4
`define DDSC_DIM_SEL_RST 1'h0
`define DDSC_PHASE_RST 1'h1
`endif

// >>> common/ddsc_pkg.sv
package ddsc_pkg;
  typedef struct packed {
    logic hi_wr;
    logic [1:0] hi;
    logic lo_wr;
    logic [7:0] lo;
  } ddsc_duty_wr_s;
  typedef enum logic [2:0] {
    DDSC_COMP_OFF = 3'h1,
    DDSC_COMP_WAIT = 3'h2,
    DDSC_COMP_ON = 3'h4
  } ddsc_comp_e;
endpackage

// >>> rtl/ddsc_dim_chan.sv
`timescale 1ns/1ns
`default_nettype none
`include "ddsc_cfg.svh"
module ddsc_dim_chan #(
  parameter int unsigned CNT_W = `DDSC_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ddsc_pkg::ddsc_duty_wr_s wr_i,
  input wire logic tick_i,
  input wire logic sync_i,
  input wire logic [CNT_W-1:0] sync_val_i,
  input wire logic [CNT_W-1:0] load_val_i,
  output logic [CNT_W-1:0] shadow_o,
  output logic [CNT_W-1:0] cnt_o,
  output logic dim_o
);
  logic [1:0] hi_q;
  logic [CNT_W-1:0] shadow_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] active_q;
  logic dim_q;

  // ----------------------------------------
  // Duty holding and shadow
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hi_q <= 2'h0;
      shadow_q <= '0;
    end
    else
    begin
      if (wr_i.hi_wr)
        hi_q <= wr_i.hi;
      if (wr_i.lo_wr)
        shadow_q <= CNT_W'({wr_i.hi_wr ? wr_i.hi : hi_q, wr_i.lo});
    end
  end

  // ----------------------------------------
  // Counter, duty load and compare
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      active_q <= '0;
      dim_q <= 1'h0;
    end
    else
    begin
      if (sync_i)
        cnt_q <= sync_val_i;
      else if (tick_i)
        cnt_q <= cnt_q + CNT_W'(1);
      if (tick_i && cnt_q == CNT_W'(`DDSC_DUTY_LOAD))
        active_q <= load_val_i;
      dim_q <= (cnt_q < active_q);
    end
  end

  assign shadow_o = shadow_q;
  assign cnt_o = cnt_q;
  assign dim_o = dim_q;

  a_hi_alone: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_i.lo_wr |=> $stable(shadow_q))
    else $error("shadow changed without low-part write");
  a_duty_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_i && cnt_q == CNT_W'(`DDSC_DUTY_LOAD) |=> active_q == $past(load_val_i))
    else $error("pending duty not loaded at 1022");
  a_duty_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(tick_i && cnt_q == CNT_W'(`DDSC_DUTY_LOAD)) |=> $stable(active_q))
    else $error("active duty changed mid period");
endmodule // ddsc_dim_chan
`default_nettype wire

// >>> rtl/ddsc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ddsc_cfg.svh"
module ddsc_top #(
  parameter int unsigned CNT_W = `DDSC_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic internal_dim_select_i,
  input wire logic dim_phase_select_i,
  input wire logic dual_phase_select_i,
  input wire logic [2:0] dim_clock_divider_i,
  input wire ddsc_pkg::ddsc_duty_wr_s [1:0] duty_wr_i,
  input wire logic [1:0] dim_input_pin_i,
  input wire logic [1:0] channel_enable_i,
  input wire logic [1:0] series_fet_drive_enable_i,
  input wire logic [1:0] channel_gate_off_i,
  input wire logic [1:0] fault_i,
  input wire logic [1:0] sense_above_comp_i,
  input wire logic [1:0][7:0] switch_div_i,
  input wire logic [1:0][7:0] softstart_clock_divider_i,
  input wire logic [1:0][2:0] phase_offset_trim_i,
  output logic [1:0] dim_active_o,
  output logic [1:0] switch_gate_out_o,
  output logic [1:0] series_fet_drive_o,
  output logic [1:0] compensation_node_connect_o,
  output logic [1:0] channel_switch_clock_o,
  output logic [1:0][7:0] softstart_ramp_dac_o,
  output logic [1:0][14:0] sense_offset_uv_o,
  output logic err_amp2_enable_o,
  output logic comp_tie_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] dim_div_len(input logic [2:0] code);
    dim_div_len = 8'h01 << code;
  endfunction

  function automatic logic [14:0] trim_uv(input logic [2:0] code);
    trim_uv = {12'h000, code} * `DDSC_TRIM_STEP_UV;
  endfunction

  function automatic logic div_done(input logic [7:0] cnt, input logic [7:0] len);
    div_done = (cnt >= len - 8'h01);
  endfunction

  // ----------------------------------------
  // Dimming clock divider
  // ----------------------------------------
  logic [7:0] div_cnt_q;
  logic tick_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt_q <= 8'h00;
      tick_q <= 1'h0;
    end
    else if (div_done(div_cnt_q, dim_div_len(dim_clock_divider_i)))
    begin
      div_cnt_q <= 8'h00;
      tick_q <= 1'h1;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 8'h01;
      tick_q <= 1'h0;
    end
  end

  // ----------------------------------------
  // Counter resynchronisation
  // ----------------------------------------
  logic sel_q;
  logic ph_q;
  logic sync;

  assign sync = (internal_dim_select_i & ~sel_q) | (dim_phase_select_i != ph_q);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_q <= `DDSC_DIM_SEL_RST;
      ph_q <= `DDSC_PHASE_RST;
    end
    else
    begin
      sel_q <= internal_dim_select_i;
      ph_q <= dim_phase_select_i;
    end
  end

  // ----------------------------------------
  // Dimming counters
  // ----------------------------------------
  logic [1:0][CNT_W-1:0] shadow;
  logic [1:0][CNT_W-1:0] cnt;
  logic [1:0][CNT_W-1:0] load_val;
  logic [1:0][CNT_W-1:0] sync_val;
  logic [1:0] int_dim;

  assign sync_val[0] = CNT_W'(0);
  assign sync_val[1] = dim_phase_select_i ? CNT_W'(0) : CNT_W'(`DDSC_PHASE_OFS);
  assign load_val[0] = shadow[0];
  assign load_val[1] = dual_phase_select_i ? shadow[0] : shadow[1];

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    ddsc_dim_chan #(
      .CNT_W(CNT_W)
    ) u_chan (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .wr_i(duty_wr_i[g]),
      .tick_i(tick_q),
      .sync_i(sync),
      .sync_val_i(sync_val[g]),
      .load_val_i(load_val[g]),
      .shadow_o(shadow[g]),
      .cnt_o(cnt[g]),
      .dim_o(int_dim[g])
    );
  end

  // ----------------------------------------
  // Effective dimming and channel gating
  // ----------------------------------------
  logic [1:0] dim_eff_d;
  logic [1:0] dim_eff_q;
  logic [1:0] fault_eff;
  logic [1:0] chan_on_d;

  assign dim_eff_d = internal_dim_select_i ? int_dim : dim_input_pin_i;
  assign fault_eff = {fault_i[1] & ~dual_phase_select_i, fault_i[0]};
  assign chan_on_d = dim_eff_d & ~channel_gate_off_i & ~fault_eff & channel_enable_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dim_eff_q <= 2'h0;
    else
      dim_eff_q <= dim_eff_d;
  end

  // ----------------------------------------
  // Switching clocks
  // ----------------------------------------
  logic [1:0][7:0] sw_cnt_q;
  logic [1:0][7:0] sw_cnt_d;
  logic [1:0] sw_clk_q;
  logic [1:0] sw_clk_d;
  logic [1:0] sw_prev_q;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (div_done(sw_cnt_q[i], switch_div_i[i]))
      begin
        sw_cnt_d[i] = 8'h00;
        sw_clk_d[i] = ~sw_clk_q[i];
      end
      else
      begin
        sw_cnt_d[i] = sw_cnt_q[i] + 8'h01;
        sw_clk_d[i] = sw_clk_q[i];
      end
    end
    if (dual_phase_select_i)
      sw_clk_d[1] = ~sw_clk_d[0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sw_cnt_q <= '0;
      sw_clk_q <= 2'h0;
      sw_prev_q <= 2'h0;
    end
    else
    begin
      sw_cnt_q <= sw_cnt_d;
      sw_clk_q <= sw_clk_d;
      sw_prev_q <= sw_clk_q;
    end
  end

  // ----------------------------------------
  // Gate and series FET drive
  // ----------------------------------------
  logic [1:0] gate_q;
  logic [1:0] fet_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate_q <= 2'h0;
      fet_q <= 2'h0;
    end
    else
    begin
      gate_q <= chan_on_d & sw_clk_d;
      fet_q <= dim_eff_d & series_fet_drive_enable_i;
    end
  end

  // ----------------------------------------
  // Compensation node connection
  // ----------------------------------------
  ddsc_pkg::ddsc_comp_e [1:0] comp_st_q;
  logic [1:0] comp_con_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      comp_st_q <= '{ddsc_pkg::DDSC_COMP_OFF, ddsc_pkg::DDSC_COMP_OFF};
      comp_con_q <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        case (comp_st_q[i])
          ddsc_pkg::DDSC_COMP_OFF:
          begin
            if (dim_eff_q[i])
              comp_st_q[i] <= ddsc_pkg::DDSC_COMP_WAIT;
          end
          ddsc_pkg::DDSC_COMP_WAIT:
          begin
            if (!dim_eff_q[i])
              comp_st_q[i] <= ddsc_pkg::DDSC_COMP_OFF;
            else if (sense_above_comp_i[i])
            begin
              comp_st_q[i] <= ddsc_pkg::DDSC_COMP_ON;
              comp_con_q[i] <= 1'h1;
            end
          end
          ddsc_pkg::DDSC_COMP_ON:
          begin
            if (!dim_eff_q[i])
            begin
              comp_st_q[i] <= ddsc_pkg::DDSC_COMP_OFF;
              comp_con_q[i] <= 1'h0;
            end
          end
          default:
          begin
            comp_st_q[i] <= ddsc_pkg::DDSC_COMP_OFF;
            comp_con_q[i] <= 1'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Soft-start ramps
  // ----------------------------------------
  logic [1:0][7:0] ss_cnt_q;
  logic [1:0][7:0] ramp_q;
  logic [1:0] sw_rise;

  assign sw_rise = sw_clk_q & ~sw_prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ss_cnt_q <= '0;
      ramp_q <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!channel_enable_i[i])
        begin
          ss_cnt_q[i] <= 8'h00;
          ramp_q[i] <= 8'h00;
        end
        else if (sw_rise[i])
        begin
          if (div_done(ss_cnt_q[i], softstart_clock_divider_i[i]))
          begin
            ss_cnt_q[i] <= 8'h00;
            if (dim_eff_q[i] && ramp_q[i] != `DDSC_RAMP_MAX)
              ramp_q[i] <= ramp_q[i] + 8'h01;
          end
          else
            ss_cnt_q[i] <= ss_cnt_q[i] + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Shared-mode and trim outputs
  // ----------------------------------------
  logic [1:0][7:0] ramp_out_q;
  logic [1:0][14:0] trim_q;
  logic amp2_q;
  logic tie_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ramp_out_q <= '0;
      trim_q <= '0;
      amp2_q <= 1'h1;
      tie_q <= 1'h0;
    end
    else
    begin
      ramp_out_q[0] <= ramp_q[0];
      ramp_out_q[1] <= dual_phase_select_i ? ramp_q[0] : ramp_q[1];
      trim_q[0] <= trim_uv(phase_offset_trim_i[0]);
      trim_q[1] <= trim_uv(phase_offset_trim_i[1]);
      amp2_q <= ~dual_phase_select_i;
      tie_q <= dual_phase_select_i;
    end
  end

  assign dim_active_o = dim_eff_q;
  assign switch_gate_out_o = gate_q;
  assign series_fet_drive_o = fet_q;
  assign compensation_node_connect_o = comp_con_q;
  assign channel_switch_clock_o = sw_clk_q;
  assign softstart_ramp_dac_o = ramp_out_q;
  assign sense_offset_uv_o = trim_q;
  assign err_amp2_enable_o = amp2_q;
  assign comp_tie_o = tie_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_wait_no_sense;
    dim_eff_q[0] && !sense_above_comp_i[0] && !compensation_node_connect_o[0];
  endsequence

  sequence s_ramp_paused;
    channel_enable_i[0] && !dim_eff_q[0];
  endsequence

  a_ext_dim_path: assert property (
    !internal_dim_select_i |=> dim_eff_q == $past(dim_input_pin_i))
    else $error("external dimming not followed");
  a_pin_ignored: assert property (
    internal_dim_select_i |=> dim_eff_q == $past(int_dim))
    else $error("dimming pin leaked into internal mode");
  a_phase_lock: assert property (
    CNT_W'(cnt[1] - cnt[0]) == (ph_q ? CNT_W'(0) : CNT_W'(`DDSC_PHASE_OFS)))
    else $error("channel counters out of phase");
  a_dim_low_off: assert property (
    !dim_eff_q[0] |-> !series_fet_drive_o[0] ##1 !compensation_node_connect_o[0])
    else $error("drive or compensation active while dimming low");
  a_comp_waits: assert property (
    s_wait_no_sense |=> !compensation_node_connect_o[0])
    else $error("compensation reconnected before sense crossing");
  a_fet_enable: assert property (
    !series_fet_drive_enable_i[1] |=> !series_fet_drive_o[1])
    else $error("series FET driven while disabled");
  a_ramp_hold: assert property (
    s_ramp_paused |=> $stable(ramp_q[0]))
    else $error("ramp moved while dimming low");
  a_dual_amp: assert property (
    dual_phase_select_i |=> !err_amp2_enable_o && comp_tie_o)
    else $error("second amplifier active in dual phase");
  a_dual_clock: assert property (
    dual_phase_select_i |=> channel_switch_clock_o[1] != channel_switch_clock_o[0])
    else $error("dual phase clocks not opposed");
  a_trim_step: assert property (
    1'b1 |=> sense_offset_uv_o[1] == trim_uv($past(phase_offset_trim_i[1])))
    else $error("trim offset wrong");
  a_gate_off: assert property (
    1'b1 |=> (switch_gate_out_o & $past(channel_gate_off_i)) == 2'h0)
    else $error("gate switching while gated off");
endmodule // ddsc_top
`default_nettype wire

// >>> tb/ddsc_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddsc_stage_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] fet_i,
  input wire logic [3:0] delay_i,
  output logic [1:0] sense_o
);
  logic [1:0][3:0] ramp_q;
  // ----------------------------------------
  // Inductor current ramp after FET turn-on
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ramp_q <= '0;
    else
      for (int c = 0; c < 2; c++)
      begin
        if (!fet_i[c])
          ramp_q[c] <= 4'h0;
        else if (ramp_q[c] != delay_i)
          ramp_q[c] <= ramp_q[c] + 4'h1;
      end
  end
  // ----------------------------------------
  // Sense above compensation once ramp done
  // ----------------------------------------
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      sense_o[c] = fet_i[c] && (ramp_q[c] == delay_i);
  end
endmodule // ddsc_stage_model
`default_nettype wire

// >>> tb/ddsc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ddsc_top_tb_top;
  logic clk, rst_n, isel, phs, dual, amp2, tie;
  logic [2:0] cdiv;
  ddsc_pkg::ddsc_duty_wr_s [1:0] dw;
  logic [1:0] pin, cen, fen, goff, flt, sense, dact, gate, fet, conn, swclk;
  logic [1:0][7:0] swdiv, ssdiv, ramp;
  logic [1:0][2:0] trim;
  logic [1:0][14:0] ofs;
  logic [3:0] dly;
  logic [31:0] n, r2;
  logic [9:0] v;
  int err_total, cmp_count;
  ddsc_top u_ddsc_top (.clk_i(clk), .rst_n_i(rst_n), .internal_dim_select_i(isel),
    .dim_phase_select_i(phs), .dual_phase_select_i(dual), .dim_clock_divider_i(cdiv),
    .duty_wr_i(dw), .dim_input_pin_i(pin), .channel_enable_i(cen),
    .series_fet_drive_enable_i(fen), .channel_gate_off_i(goff), .fault_i(flt),
    .sense_above_comp_i(sense), .switch_div_i(swdiv), .softstart_clock_divider_i(ssdiv),
    .phase_offset_trim_i(trim), .dim_active_o(dact), .switch_gate_out_o(gate),
    .series_fet_drive_o(fet), .compensation_node_connect_o(conn),
    .channel_switch_clock_o(swclk), .softstart_ramp_dac_o(ramp),
    .sense_offset_uv_o(ofs), .err_amp2_enable_o(amp2), .comp_tie_o(tie));
  ddsc_stage_model u_ddsc_stage_model (.clk_i(clk), .rst_n_i(rst_n), .fet_i(fet),
    .delay_i(dly), .sense_o(sense));
  // ----------------------------------------
  // Checking and stimulus tasks
  // ----------------------------------------
  task automatic stop_test;
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] exp_high(input logic [9:0] d, input int k);
    exp_high = 32'(d) << k;
  endfunction
  function automatic logic [31:0] exp_ofs(input int code);
    exp_ofs = 32'(code * 2500);
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic duty(input int c, input logic [9:0] d);
    dw[c].hi_wr = 1'h1;
    dw[c].hi = d[9:8];
    cyc(1);
    dw[c].hi_wr = 1'h0;
    dw[c].lo_wr = 1'h1;
    dw[c].lo = d[7:0];
    cyc(1);
    dw[c].lo_wr = 1'h0;
  endtask
  task automatic cnt(input int c, input int k, input bit g, output logic [31:0] h);
    h = 0;
    repeat (k)
    begin
      if (isel)
        pin = 2'($urandom);
      cyc(1);
      h += g ? gate[c] : dact[c];
    end
  endtask
  task automatic gap(output logic [31:0] d);
    int t0;
    logic [1:0] p;
    t0 = -1;
    d = 32'hFFFFFFFF;
    p = dact;
    for (int t = 0; t < 3000; t++)
    begin
      cyc(1);
      if (dact[0] && !p[0] && t0 < 0)
        t0 = t;
      if (dact[1] && !p[1] && t0 >= 0)
      begin
        d = t - t0;
        break;
      end
      p = dact;
    end
    if (d === 32'hFFFFFFFF)
    begin
      err_total++;
      stop_test();
    end
  endtask
  // ----------------------------------------
  // Clock
  // ----------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, isel, phs, dual, cdiv, dw, pin, goff, flt, trim} = '0;
    {cen, fen} = 4'hF;
    swdiv = 16'h0202;
    ssdiv = 16'h0101;
    dly = 4'hC;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'h14A9));
    cyc(6);
    rst_n = 1'h1;
    cyc(2);
    chk("dim_active", 0, dact);
    chk("err_amp2", 1, amp2);
    chk("comp_tie", 0, tie);
    pin = 2'h3;
    cyc(2);
    chk("dim_active", 3, dact);
    chk("fet_drive", 3, fet);
    cyc(8);
    chk("connect_wait", 0, conn);
    cyc(8);
    chk("connect_on", 3, conn);
    fen = 2'h1;
    cyc(2);
    chk("fet_disabled", 1, fet);
    cnt(0, 32, 1, n);
    chk("gate_run", 1, n > 0 && n < 32);
    goff = 2'h2;
    cnt(1, 32, 1, n);
    chk("gate_off", 0, n);
    cnt(0, 32, 1, n);
    chk("gate_other", 1, n > 0);
    goff = 2'h0;
    pin = 2'h0;
    cyc(3);
    chk("dim_low_fet", 0, fet);
    chk("dim_low_conn", 0, conn);
    cnt(0, 16, 1, n);
    chk("dim_low_gate", 0, n);
    dly = 4'h1;
    fen = 2'h3;
    pin = 2'h3;
    cyc(6);
    chk("connect_prompt", 3, conn);
    cen = 2'h0;
    cyc(3);
    chk("ramp_clear", 0, ramp[0]);
    cen = 2'h3;
    cyc(40);
    chk("ramp_up", 1, ramp[0] != 0);
    pin = 2'h0;
    cyc(3);
    r2 = ramp[0];
    cyc(40);
    chk("ramp_hold", r2, ramp[0]);
    pin = 2'h3;
    cyc(1200);
    chk("ramp_top", 32'hFF, ramp[0]);
    for (int k = 0; k < 8; k++)
    begin
      trim = {3'(7 - k), 3'(k)};
      cyc(2);
      chk("offset0", exp_ofs(k), ofs[0]);
      chk("offset1", exp_ofs(7 - k), ofs[1]);
    end
    isel = 1'h1;
    phs = 1'h1;
    for (int k = 0; k < 6; k++)
    begin
      v = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : (k == 2) ? 10'h001 : 10'($urandom);
      duty(0, v);
      duty(1, v ^ 10'h155);
      cyc(2100);
      cnt(0, 1024, 0, n);
      chk("duty0", exp_high(v, 0), n);
      cnt(1, 1024, 0, n);
      chk("duty1", exp_high(v ^ 10'h155, 0), n);
    end
    dw[0].hi_wr = 1'h1;
    dw[0].hi = ~v[9:8];
    cyc(1);
    dw[0].hi_wr = 1'h0;
    cyc(2100);
    cnt(0, 1024, 0, n);
    chk("high_only", exp_high(v, 0), n);
    for (int k = 1; k < 3; k++)
    begin
      cdiv = 3'(k);
      cyc((1024 << k) + 16);
      cnt(0, 1024 << k, 0, n);
      chk("divided", exp_high(v, k), n);
    end
    cdiv = 3'h0;
    duty(0, 10'h064);
    duty(1, 10'h064);
    phs = 1'h0;
    cyc(2100);
    gap(n);
    chk("phase_180", 512, n);
    phs = 1'h1;
    cyc(2100);
    gap(n);
    chk("phase_0", 0, n);
    duty(0, 10'h3F0);
    duty(1, 10'h010);
    swdiv[1] = 8'h07;
    flt = 2'h2;
    dual = 1'h1;
    cyc(2100);
    chk("amp2_off", 0, amp2);
    chk("comp_tied", 1, tie);
    repeat (8)
    begin
      cyc(1);
      chk("swclk_anti", !swclk[0], swclk[1]);
      chk("ramp_shared", ramp[0], ramp[1]);
    end
    cnt(1, 1024, 0, n);
    chk("dual_duty", exp_high(10'h3F0, 0), n);
    cnt(1, 64, 1, n);
    chk("fault2_ignored", 1, n > 0);
    stop_test();
  end
endmodule // ddsc_top_tb_top
`default_nettype wire
